// file: sio_map.vh
// Register map, field positions, reset values and mode and clock codes of the buffered serial port.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef SIO_MAP_VH
`define SIO_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL_ONE   8'h00
`define OFS_CTRL_TWO   8'h04
`define OFS_STATUS     8'h08
`define OFS_BUF_BASE   8'h20
`define OFS_BUF_LAST   8'h3c

// ----------------------------------------
// Control one fields
// ----------------------------------------
`define C1_START       7
`define C1_INHIBIT     6
`define C1_MODE_HI     5
`define C1_MODE_LO     3
`define C1_CLK_HI      2
`define C1_CLK_LO      0
`define C1_RESET       8'h40

// ----------------------------------------
// Control two fields
// ----------------------------------------
`define C2_COUNT_HI    2
`define C2_COUNT_LO    0
`define C2_RESET       8'h00

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_XFER        7
`define ST_SHIFT       6

// ----------------------------------------
// Modes and clock codes
// ----------------------------------------
`define MODE_TX4       3'b000
`define MODE_TX8       3'b001
`define MODE_TXRX8     3'b100
`define MODE_RX8       3'b101
`define MODE_RX4       3'b110
`define CLK_RESERVED   3'b110
`define CLK_EXTERNAL   3'b111

`endif

// file: sio_clk_div.v
// Divider that makes one-cycle half-period enables for the internal serial clock.
// Assumes one system clock; the select code arrives from a register on that clock.
`timescale 1ns/100ps

module sio_clk_div (
	// Clock and reset
	input  wire       hclk,
	input  wire       hresetn,
	// Control
	input  wire       run,
	input  wire [2:0] sel,
	// Half-period tick
	output reg        tick
);

	reg  [12:0] cnt_q;
	reg  [12:0] lim;

	// Half periods of 2^12 and 2^7 .. 2^3 give full periods of 2^13 and 2^8 .. 2^4.
	always @* begin
		case (sel)
			3'b000:  lim = 13'h0fff;
			3'b001:  lim = 13'h007f;
			3'b010:  lim = 13'h003f;
			3'b011:  lim = 13'h001f;
			3'b100:  lim = 13'h000f;
			3'b101:  lim = 13'h0007;
			default: lim = 13'h0007;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 13'h0000;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= 13'h0000;
			tick  <= 1'b0;
		end else if (cnt_q >= lim) begin
			cnt_q <= 13'h0000;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 13'h0001;
			tick  <= 1'b0;
		end
	end

endmodule

// file: sio_port.v
// Buffered three-wire synchronous serial port with eight word buffers on AHB-Lite.
// Assumes a single AHB-Lite master, word transfers only, and an external clock far slower than hclk.
//
// What this block does
// - Serial output changes on the falling edge of the serial clock pin.
// - Serial input is sampled on the rising edge of the serial clock pin.
// - Four-bit words use the low nibble; received upper nibble reads zero.
// - Every word travels least significant bit first.
// - A burst carries one to eight words, as the word count says.
// - The interrupt rises once the programmed words have been transferred.
// - Start begins a transmit burst; each buffer loads as its first bit leaves.
// - After the last transmit bit with the buffer empty, raise buffer-empty interrupt.
// - Internal clock transmit halts until at least one new word is written.
// - A write to any buffer, even unused, releases the automatic wait.
// - Clearing start while transmitting finishes the current word, then clears active flag.
// - Inhibit ends any operation at once, clears active flag, drops partial data.
// - External clock transmit without new data sends dummy data and ends.
// - Receive stores each word into the next buffer; full burst raises interrupt.
// - Internal clock receive halts until any buffer is read.
// - External clock receive with unread data drops the word and stops receiving.
// - Clearing start while receiving completes and stores the current word, then stops.
// - Combined mode shares buffers; internal clock waits for a buffer write only.
// - Changing the transfer mode discards buffer contents.
// - Count 000 means one word up to 111 eight; buffers used from lowest.
// - Status shows transfer-active and shift-active flags, one while in progress.
// - With internal clock the clock pin is driven high when a transfer starts.
`timescale 1ns/100ps
`include "sio_map.vh"

module sio_port (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Serial pins
	input  wire        sck_in,
	output reg         sck_out,
	output reg         sck_oe,
	input  wire        si_in,
	output reg         so_out,
	// Interrupt strobe
	output reg         serial_irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_SHIFT = 2'd1;
	localparam ST_WAIT = 2'd2;

	reg  [7:0]  serial_ctrl_one_q;
	reg  [2:0]  word_count_q;
	reg  [7:0]  data_buffer_regs [0:7];
	reg  [1:0]  state_q;
	reg  [7:0]  shreg_q;
	reg  [2:0]  bit_q;
	reg  [2:0]  word_q;
	reg         transfer_active_flag_q;
	reg         stop_req_q;
	reg         service_q;
	reg         sck_int_q;
	reg  [1:0]  sck_sync_q;
	reg         sck_prev_q;
	reg  [1:0]  si_sync_q;
	reg         ph_w_q;
	reg         ph_sel_q;
	reg  [2:0]  ph_idx_q;

	wire        xfer_start_bit   = serial_ctrl_one_q[`C1_START];
	wire        xfer_inhibit_bit = serial_ctrl_one_q[`C1_INHIBIT];
	wire [2:0]  xfer_mode_field  = serial_ctrl_one_q[`C1_MODE_HI:`C1_MODE_LO];
	wire [2:0]  clk_sel          = serial_ctrl_one_q[`C1_CLK_HI:`C1_CLK_LO];
	wire        ext_clk          = (clk_sel == `CLK_EXTERNAL);
	wire        four_bit         = (xfer_mode_field == `MODE_TX4) || (xfer_mode_field == `MODE_RX4);
	wire        do_tx            = (xfer_mode_field == `MODE_TX4) || (xfer_mode_field == `MODE_TX8) ||
	                               (xfer_mode_field == `MODE_TXRX8);
	wire        do_rx            = (xfer_mode_field == `MODE_RX4) || (xfer_mode_field == `MODE_RX8) ||
	                               (xfer_mode_field == `MODE_TXRX8);
	wire [2:0]  last_bit         = four_bit ? 3'd3 : 3'd7;
	wire        shift_active_flag = (state_q == ST_SHIFT);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire        take    = hsel && hready && htrans[1];
	wire [7:0]  ph_addr;
	reg  [7:0]  ph_addr_q;
	assign ph_addr = ph_addr_q;
	wire        ph_is_buf = (ph_addr >= `OFS_BUF_BASE) && (ph_addr <= `OFS_BUF_LAST);
	wire [2:0]  buf_idx   = ph_idx_q;
	wire        buf_wr    = ph_w_q && ph_sel_q && ph_is_buf;
	wire        ctrl1_wr  = ph_w_q && ph_sel_q && (ph_addr == `OFS_CTRL_ONE);
	wire        ctrl2_wr  = ph_w_q && ph_sel_q && (ph_addr == `OFS_CTRL_TWO);
	wire        buf_rd    = take && !hwrite && (haddr >= `OFS_BUF_BASE) && (haddr <= `OFS_BUF_LAST);
	wire        mode_chg  = ctrl1_wr && (hwdata[`C1_MODE_HI:`C1_MODE_LO] != xfer_mode_field);
	// A buffer access that meets the end of a burst must not be lost, so the clear takes it in.
	wire        svc_hit   = (buf_wr && do_tx) || (buf_rd && do_rx && !do_tx);

	// ----------------------------------------
	// Serial clock and pin synchronisers
	// ----------------------------------------
	wire        tick;

	sio_clk_div u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     ((state_q == ST_SHIFT) && !ext_clk && (clk_sel != `CLK_RESERVED)),
		.sel     (clk_sel),
		.tick    (tick)
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_sync_q <= 2'b11;
			sck_prev_q <= 1'b1;
			si_sync_q  <= 2'b00;
		end else begin
			sck_sync_q <= {sck_sync_q[0], sck_in};
			sck_prev_q <= sck_sync_q[1];
			si_sync_q  <= {si_sync_q[0], si_in};
		end
	end

	wire        int_fall = tick && sck_int_q;
	wire        int_rise = tick && !sck_int_q;
	wire        ext_fall = sck_prev_q && !sck_sync_q[1];
	wire        ext_rise = !sck_prev_q && sck_sync_q[1];
	wire        lead     = ext_clk ? ext_fall : int_fall;
	wire        trail    = ext_clk ? ext_rise : int_rise;
	wire        burst_end = (word_q == word_count_q);

	// ----------------------------------------
	// Registers and serial engine
	// ----------------------------------------
	integer i;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_ctrl_one_q      <= `C1_RESET;
			word_count_q           <= 3'd0;
			state_q                <= ST_IDLE;
			shreg_q                <= 8'h00;
			bit_q                  <= 3'd0;
			word_q                 <= 3'd0;
			transfer_active_flag_q <= 1'b0;
			stop_req_q             <= 1'b0;
			service_q              <= 1'b0;
			sck_int_q              <= 1'b1;
			so_out                 <= 1'b1;
			sck_out                <= 1'b1;
			sck_oe                 <= 1'b0;
			serial_irq             <= 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				data_buffer_regs[i] <= 8'h00;
			end
		end else begin
			serial_irq <= 1'b0;
			sck_out    <= sck_int_q;
			sck_oe     <= !ext_clk;
			if (ctrl2_wr) begin
				word_count_q <= hwdata[`C2_COUNT_HI:`C2_COUNT_LO];
			end
			if (buf_wr) begin
				data_buffer_regs[buf_idx] <= hwdata[7:0];
			end
			// A buffer write in transmit modes, or a read in receive-only modes, counts as service, so an unused buffer releases the wait too.
			if (svc_hit) begin
				service_q <= 1'b1;
			end
			if (mode_chg) begin
				for (i = 0; i < 8; i = i + 1) begin
					data_buffer_regs[i] <= 8'h00;
				end
			end
			if (ctrl1_wr) begin
				serial_ctrl_one_q <= hwdata[7:0];
			end
			if (ctrl1_wr && hwdata[`C1_INHIBIT]) begin
				state_q                <= ST_IDLE;
				transfer_active_flag_q <= 1'b0;
				sck_int_q              <= 1'b1;
				so_out                 <= 1'b1;
				stop_req_q             <= 1'b0;
			end else begin
				if (ctrl1_wr && !hwdata[`C1_START] && transfer_active_flag_q) begin
					stop_req_q <= 1'b1;
				end
				case (state_q)
					ST_IDLE: begin
						if (ctrl1_wr && hwdata[`C1_START] && !hwdata[`C1_INHIBIT]) begin
							state_q                <= ST_SHIFT;
							transfer_active_flag_q <= 1'b1;
							bit_q                  <= 3'd0;
							word_q                 <= 3'd0;
							sck_int_q              <= 1'b1;
							service_q              <= svc_hit;
							stop_req_q             <= 1'b0;
						end
					end
					ST_SHIFT: begin
						if (!ext_clk && tick) begin
							sck_int_q <= !sck_int_q;
						end
						if (lead) begin
							if (bit_q == 3'd0) begin
								// The buffer moves into the shifter as its first bit leaves.
								// When receiving, the trailing edge does the shift, so the leading edge only loads.
								shreg_q <= do_rx ? data_buffer_regs[word_q] :
								           {1'b0, data_buffer_regs[word_q][7:1]};
								so_out  <= do_tx ? data_buffer_regs[word_q][0] : 1'b1;
							end else begin
								// A second shift per bit would scramble the incoming word.
								if (!do_rx) begin
									shreg_q <= {1'b0, shreg_q[7:1]};
								end
								so_out  <= do_tx ? shreg_q[0] : 1'b1;
							end
						end
						if (trail) begin
							if (do_rx) begin
								if (four_bit) begin
									shreg_q <= {4'h0, si_sync_q[1], shreg_q[3:1]};
								end else begin
									shreg_q <= {si_sync_q[1], shreg_q[7:1]};
								end
							end
							if (bit_q == last_bit) begin
								bit_q <= 3'd0;
								if (do_rx) begin
									if (four_bit) begin
										data_buffer_regs[word_q] <= {4'h0, si_sync_q[1], shreg_q[3:1]};
									end else begin
										data_buffer_regs[word_q] <= {si_sync_q[1], shreg_q[7:1]};
									end
								end
								if (stop_req_q || (ctrl1_wr && !hwdata[`C1_START])) begin
									state_q                <= ST_IDLE;
									transfer_active_flag_q <= 1'b0;
									sck_int_q              <= 1'b1;
									serial_irq             <= 1'b1;
								end else if (burst_end) begin
									serial_irq <= 1'b1;
									word_q     <= 3'd0;
									service_q  <= svc_hit;
									state_q    <= ST_WAIT;
									sck_int_q  <= 1'b1;
								end else begin
									word_q <= word_q + 3'd1;
								end
							end else begin
								bit_q <= bit_q + 3'd1;
							end
						end
					end
					ST_WAIT: begin
						if (stop_req_q || !xfer_start_bit) begin
							state_q                <= ST_IDLE;
							transfer_active_flag_q <= 1'b0;
						end else if (ext_clk) begin
							// The far side may clock again at once; unserviced buffers end the job.
							if (ext_fall) begin
								if (service_q) begin
									state_q <= ST_SHIFT;
									shreg_q <= do_rx ? data_buffer_regs[0] : {1'b0, data_buffer_regs[0][7:1]};
									so_out  <= do_tx ? data_buffer_regs[0][0] : 1'b1;
									bit_q   <= 3'd0;
								end else begin
									so_out                 <= 1'b1;
									state_q                <= ST_IDLE;
									transfer_active_flag_q <= 1'b0;
								end
							end
						end else if (service_q) begin
							state_q <= ST_SHIFT;
							bit_q   <= 3'd0;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// AHB-Lite data phase
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_w_q    <= 1'b0;
			ph_sel_q  <= 1'b0;
			ph_idx_q  <= 3'd0;
			ph_addr_q <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ph_w_q    <= take && hwrite;
			ph_sel_q  <= take;
			ph_idx_q  <= haddr[4:2];
			ph_addr_q <= haddr;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take && !hwrite) begin
				if (haddr == `OFS_STATUS) begin
					hrdata <= {24'h000000, transfer_active_flag_q, shift_active_flag, 6'h00};
				end else if ((haddr >= `OFS_BUF_BASE) && (haddr <= `OFS_BUF_LAST)) begin
					hrdata <= {24'h000000, data_buffer_regs[haddr[4:2]]};
				end else begin
					hrdata <= 32'h00000000;
				end
			end
		end
	end

endmodule

// file: sio_checker.sv
// Port-level checks for the buffered serial port.
// Assumes it is bound to the port and sees its ports only.
`timescale 1ns/100ps

module sio_checker (
	// Clock and reset
	input wire        hclk,
	input wire        hresetn,
	// Bus
	input wire        hsel,
	input wire [7:0]  haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	// Serial pins and interrupt
	input wire        sck_out,
	input wire        sck_oe,
	input wire        so_out,
	input wire        serial_irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	wire rd   = hsel && hready && htrans[1] && !hwrite;
	// Control registers read as zero, so they count with the holes.
	wire hole = haddr < 8'h08 || (haddr > 8'h0b && haddr < 8'h20) || haddr > 8'h3f;

	okay_resp_a: assert property (hresp == 1'b0 && hreadyout)
		else $error("bus answer not ready or not okay");
	hole_read_a: assert property (rd && hole |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	status_bits_a: assert property (rd && haddr == 8'h08 |=> hrdata[31:8] == 24'h0 && hrdata[5:0] == 6'h0)
		else $error("status unused bits not zero");
	read_hold_a: assert property (!rd |=> $stable(hrdata))
		else $error("read data moved without a read");
	irq_pulse_a: assert property (serial_irq |=> !serial_irq)
		else $error("interrupt longer than one cycle");
	irq_sck_a: assert property (serial_irq && sck_oe |=> sck_out)
		else $error("interrupt in mid bit");
	sck_idle_a: assert property (!sck_oe |-> sck_out)
		else $error("clock output not high when idle");
	sck_start_a: assert property ($rose(sck_oe) |-> sck_out)
		else $error("clock output not high at start");
	low_half_a: assert property ($fell(sck_out) |-> !sck_out [*8])
		else $error("clock low half too short");
	so_steady_a: assert property (sck_oe && $rose(sck_out) |-> $stable(so_out))
		else $error("serial output moved on rising clock");
endmodule

// file: sio_peer.sv
// Serial peripheral on the far side of the port's three wires.
// Assumes the port supplies the clock; the bench fills and empties its bit queues.
`timescale 1ns/100ps

module sio_peer (
	// Serial pins
	input  wire sck,
	input  wire so,
	output reg  si
);
	bit tx_bits[$];
	bit rx_bits[$];

	initial si = 1'b0;
	// Bits are taken in arrival order, so the first one is the word's lowest.
	always @(posedge sck)
		rx_bits.push_back(so);
	// With nothing to send the line flips, so a stale bit never looks valid.
	always @(negedge sck) begin
		if (tx_bits.size() > 0)
			si = tx_bits.pop_front();
		else
			si = ~si;
	end
endmodule

// file: buffered_sync_serial_port_tb.sv
// Self-checking bench for the buffered serial port.
// Assumes the port, its checker and the peer model are compiled before it.
`timescale 1ns/100ps
`include "sio_map.vh"

module buffered_sync_serial_port_tb;
	reg          hclk    = 1'b0;
	reg          hresetn = 1'b0;
	reg          hsel    = 1'b0;
	reg  [7:0]   haddr   = 8'h00;
	reg  [1:0]   htrans  = 2'b00;
	reg          hwrite  = 1'b0;
	reg  [2:0]   hsize   = 3'b010;
	reg  [31:0]  hwdata  = 32'h0;
	wire [31:0]  hrdata;
	wire         hreadyout, hresp, sck_out, sck_oe, so_out, serial_irq, si;
	// The clock pin has a pull-up and rests high when nobody drives it.
	wire         sck = sck_oe ? sck_out : 1'b1;
	int          errors = 0;
	int          n_checks = 0;
	int          irqs = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic [31:0] tx_q[$];
	logic [31:0] rx_q[$];

	always #2.5 hclk = ~hclk;

	sio_port dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si), .so_out(so_out),
		.serial_irq(serial_irq)
	);
	sio_peer peer (.sck(sck), .so(so_out), .si(si));

	always @(posedge hclk) begin
		cycles++;
		if (serial_irq === 1'b1)
			irqs++;
		if (cycles == 30000) begin
			errors++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One single word transfer; entered just after a rising edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task results;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One burst on the chosen internal clock, stopped by a cleared start, then inhibit.
	task automatic run(input logic [2:0] mode, input logic [2:0] cnt, input logic [2:0] clk);
		logic [31:0] v;
		logic [31:0] g;
		logic [31:0] mask;
		logic        tx;
		int          n0;
		mask = (mode == `MODE_TX4 || mode == `MODE_RX4) ? 32'hf : 32'hff;
		tx = !mode[2] || mode == `MODE_TXRX8;
		bus(1'b1, `OFS_CTRL_ONE, {24'h0, 2'b01, mode, clk});
		bus(1'b1, `OFS_CTRL_TWO, {29'h0, cnt});
		peer.rx_bits.delete();
		peer.tx_bits.delete();
		for (int i = 0; i <= cnt; i++) begin
			v = $urandom;
			if (tx) begin
				bus(1'b1, `OFS_BUF_BASE + 8'(4 * i), {24'h0, v[7:0]});
				tx_q.push_back(v & mask);
			end
			if (mode[2]) begin
				for (int b = 0; b < (mask == 32'hf ? 4 : 8); b++)
					peer.tx_bits.push_back(v[b + 8]);
				rx_q.push_back((v >> 8) & mask);
			end
		end
		n0 = irqs;
		bus(1'b1, `OFS_CTRL_ONE, {24'h0, 2'b10, mode, clk});
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h80);
		wait (irqs != n0);
		if (mode[2])
			bus(1'b1, `OFS_CTRL_TWO, {29'h0, cnt});
		// Ending by a cleared start lets the buffers be read without releasing another burst.
		bus(1'b1, `OFS_CTRL_ONE, {24'h0, 2'b00, mode, clk});
		for (int i = 0; rx_q.size() > 0; i++) begin
			bus(1'b0, `OFS_BUF_BASE + 8'(4 * i), 32'h0);
			chk(rd, rx_q.pop_front());
		end
		bus(1'b1, `OFS_CTRL_ONE, {24'h0, 2'b01, mode, clk});
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		while (tx_q.size() > 0) begin
			g = 32'h0;
			for (int b = 0; b < (mask == 32'hf ? 4 : 8); b++)
				g[b] = peer.rx_bits.size() > 0 ? peer.rx_bits.pop_front() : 1'bx;
			chk(g, tx_q.pop_front());
		end
		$display("test mode %h count %h done", mode, cnt);
	endtask

	initial begin
		void'($urandom(32'haee229d2));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
		run(`MODE_TX8, 3'h2, 3'h4);
		run(`MODE_TX4, 3'h0, 3'h5);
		run(`MODE_RX8, 3'h7, 3'h5);
		run(`MODE_RX4, 3'h3, 3'h3);
		run(`MODE_TXRX8, 3'h1, 3'h5);
		bus(1'b1, `OFS_BUF_BASE, 32'h5a);
		bus(1'b1, `OFS_CTRL_ONE, {24'h0, 2'b01, `MODE_RX8, `CLK_EXTERNAL});
		bus(1'b0, `OFS_BUF_BASE, 32'h0);
		chk(rd, 32'h0);
		// No external clock arrives, so the transfer stays pending until inhibit.
		bus(1'b1, `OFS_CTRL_ONE, {24'h0, 2'b10, `MODE_RX8, `CLK_EXTERNAL});
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h80);
		bus(1'b1, `OFS_CTRL_ONE, {24'h0, 2'b01, `MODE_RX8, `CLK_EXTERNAL});
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("test external inhibit done");
		results();
	end
endmodule

bind sio_port sio_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.hreadyout, .hresp, .sck_out, .sck_oe, .so_out, .serial_irq);
